/* File: verilog/imc_pkg.sv */
// package for the two-wire master control block
package imc_pkg;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_SYNC = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h1a;
    localparam logic [31:0] CTRL_A_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_B_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_A_WMASK = 32'h7bf1_009f;
    localparam int A_SOFT_RESET = 0;
    localparam int A_ENABLE = 1;
    localparam int A_MODE_LO = 2;
    localparam int A_STANDBY = 7;
    localparam int A_FOUR_WIRE = 16;
    localparam int A_HOLD_LO = 20;
    localparam int A_MEXT = 22;
    localparam int A_SEXT = 23;
    localparam int A_SPEED_LO = 24;
    localparam int A_STRETCH = 27;
    localparam int A_INACT_LO = 28;
    localparam int B_SMART = 8;
    localparam int B_CMD_LO = 16;
    localparam int B_ACK = 18;
    localparam logic [2:0] MODE_MASTER = 3'h5;
    localparam int CLK_MHZ = 125;
    localparam int SYNC_CYCLES = 4;
    localparam int SLAVE_EXT_MS = 25;
    localparam int MASTER_EXT_MS = 10;
    localparam int SLAVE_EXT_CYCLES = SLAVE_EXT_MS * 1000 * CLK_MHZ;
    localparam int MASTER_EXT_CYCLES = MASTER_EXT_MS * 1000 * CLK_MHZ;
    localparam int HOLD1_NS = 50;
    localparam int HOLD2_NS = 300;
    localparam int HOLD3_NS = 400;
    localparam int HOLD1_CYCLES = (HOLD1_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD2_CYCLES = (HOLD2_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD3_CYCLES = (HOLD3_NS * CLK_MHZ + 999) / 1000;
    localparam int INACT1_PERIODS = 5;
    localparam int INACT2_PERIODS = 10;
    localparam int INACT3_PERIODS = 20;
    typedef enum logic [1:0] {CMD_NONE, CMD_RESTART, CMD_READ, CMD_STOP} imc_cmd_type;
    typedef enum logic [1:0] {BUS_UNKNOWN, BUS_IDLE, BUS_OWNER, BUS_BUSY} imc_bus_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } imc_req_type;
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } imc_rsp_type;
    typedef struct packed {
        logic restart;
        logic read_byte;
        logic stop;
        logic send_nack;
        logic ack_valid;
    } imc_op_type;
endpackage : imc_pkg

/* File: verilog/imc_master_control.sv */
// control register block of the two-wire bus master
`timescale 1ns/10ps
module imc_master_control #(
    parameter int SLAVE_EXT_LIMIT = imc_pkg::SLAVE_EXT_CYCLES,
    parameter int MASTER_EXT_LIMIT = imc_pkg::MASTER_EXT_CYCLES
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire imc_pkg::imc_req_type req_i,
    input wire logic scl_i,
    input wire logic master_reading_i,
    input wire logic data_read_i,
    input wire logic addr_write_i,
    input wire logic op_done_i,
    input wire logic bus_start_i,
    input wire logic bus_ack_i,
    input wire logic bus_stop_i,
    input wire logic standby_i,
    output imc_pkg::imc_rsp_type rsp_o,
    output imc_pkg::imc_op_type op_o,
    output logic core_clock_en_o,
    output logic module_enabled_o,
    output logic four_wire_o,
    output logic [1:0] speed_o,
    output logic [5:0] hold_cycles_o,
    output logic stretch_after_ack_o,
    output imc_pkg::imc_bus_type bus_state_o,
    output logic clock_hold_release_o,
    output logic extend_timeout_status_o,
    output logic bus_error_status_o,
    output logic master_on_bus_flag_o
);
    import imc_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl_a;
        logic [31:0] ctrl_b;
        logic enable_busy;
        logic reset_busy;
        logic system_operation_busy;
        logic [2:0] sync_cnt;
        logic [1:0] scl_sync;
        logic scl_prev;
        logic [15:0] scl_low_cnt;
        logic [4:0] low_periods;
        logic [15:0] period_cnt;
        logic [15:0] scl_period;
        logic [31:0] sext_cnt;
        logic [31:0] mext_cnt;
        logic in_frame;
        imc_rsp_type rsp;
        imc_op_type op;
        imc_bus_type bus;
        logic clock_hold_release;
        logic extend_timeout_status;
        logic bus_error_status;
        logic master_on_bus_flag;
        logic core_clock_en;
        logic module_enabled;
        logic [5:0] hold_cycles;
    } imc_state_type;

    imc_state_type st;
    imc_state_type next_st;

    function automatic logic [4:0] inact_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0: inact_limit = 5'h0;
            2'h1: inact_limit = 5'(INACT1_PERIODS);
            2'h2: inact_limit = 5'(INACT2_PERIODS);
            2'h3: inact_limit = 5'(INACT3_PERIODS);
        endcase
    endfunction : inact_limit

    function automatic logic [5:0] hold_sel(input logic [1:0] sel);
        unique case (sel)
            2'h0: hold_sel = 6'h0;
            2'h1: hold_sel = 6'(HOLD1_CYCLES);
            2'h2: hold_sel = 6'(HOLD2_CYCLES);
            2'h3: hold_sel = 6'(HOLD3_CYCLES);
        endcase
    endfunction : hold_sel

    logic scl_fall;
    logic scl_rise;
    logic scl_low;
    logic wr_a;
    logic wr_b;
    logic extend_hit;
    logic [1:0] cmd;

    always_comb begin
        next_st = st;
        scl_low = ~st.scl_sync[1];
        // only the second stage is looked at
        scl_fall = st.scl_prev & ~st.scl_sync[1];
        scl_rise = ~st.scl_prev & st.scl_sync[1];
        wr_a = req_i.wr && req_i.addr == OFS_CTRL_A;
        wr_b = req_i.wr && req_i.addr == OFS_CTRL_B;
        cmd = req_i.wdata[B_CMD_LO +: 2];
        extend_hit = 1'b0;
        next_st.scl_sync = {st.scl_sync[0], scl_i};
        next_st.scl_prev = st.scl_sync[1];
        next_st.op = '0;
        next_st.rsp = '0;
        next_st.clock_hold_release = 1'b0;

        // synchroniser for enable and reset
        // runs ahead of the bus access so a fresh write restarts the count
        if (st.sync_cnt != 3'h0) begin
            next_st.sync_cnt = st.sync_cnt - 3'h1;
        end else begin
            if (st.enable_busy) begin
                next_st.module_enabled = st.ctrl_a[A_ENABLE];
                next_st.enable_busy = 1'b0;
            end
            if (st.reset_busy) begin
                next_st.reset_busy = 1'b0;
                next_st.ctrl_a = CTRL_A_RESET;
            end
        end

        // bus access
        if (req_i.wr && st.reset_busy) begin
            next_st.rsp.err = 1'b1;
        end else if (wr_a && req_i.wdata[A_SOFT_RESET]) begin
            // soft reset wins, rest of the write is dropped
            next_st.ctrl_a = CTRL_A_RESET | 32'h1;
            next_st.ctrl_b = CTRL_B_RESET;
            next_st.reset_busy = 1'b1;
            next_st.enable_busy = 1'b0;
            next_st.system_operation_busy = 1'b0;
            next_st.module_enabled = 1'b0;
            next_st.extend_timeout_status = 1'b0;
            next_st.bus_error_status = 1'b0;
            next_st.master_on_bus_flag = 1'b0;
            next_st.sync_cnt = 3'(SYNC_CYCLES);
        end else if (wr_a) begin
            next_st.ctrl_a = req_i.wdata & CTRL_A_WMASK;
            if (req_i.wdata[A_ENABLE] != st.ctrl_a[A_ENABLE]) begin
                next_st.enable_busy = 1'b1;
                next_st.sync_cnt = 3'(SYNC_CYCLES);
            end
        end else if (wr_b) begin
            // ack bit and smart bit kept, command bits never stored
            next_st.ctrl_b = {13'h0, req_i.wdata[B_ACK], 9'h0, req_i.wdata[B_SMART], 8'h0};
            if (cmd != 2'(CMD_NONE)) begin
                next_st.system_operation_busy = 1'b1;
                // the command hands the bus back to the engine
                next_st.master_on_bus_flag = 1'b0;
                next_st.op.send_nack = req_i.wdata[B_ACK];
                next_st.op.ack_valid = master_reading_i;
                next_st.op.restart = cmd == 2'(CMD_RESTART);
                next_st.op.read_byte = cmd == 2'(CMD_READ) && master_reading_i;
                next_st.op.stop = cmd == 2'(CMD_STOP);
            end
        end
        if (addr_write_i && !st.reset_busy) begin
            next_st.op.restart = 1'b1;
            next_st.system_operation_busy = 1'b1;
        end
        if (data_read_i && st.ctrl_b[B_SMART] && master_reading_i) begin
            next_st.op.send_nack = st.ctrl_b[B_ACK];
            next_st.op.ack_valid = 1'b1;
        end
        if (op_done_i && !next_st.op.restart && !wr_b) begin
            next_st.system_operation_busy = 1'b0;
        end

        if (req_i.rd) begin
            unique case (req_i.addr)
                OFS_CTRL_A: next_st.rsp.rdata = st.reset_busy ? 32'h1 : st.ctrl_a;
                OFS_CTRL_B: next_st.rsp.rdata = st.reset_busy ? CTRL_B_RESET : st.ctrl_b;
                OFS_SYNC: next_st.rsp.rdata = {29'h0, st.system_operation_busy,
                    st.enable_busy, st.reset_busy};
                OFS_STATUS: next_st.rsp.rdata = {22'h0, st.extend_timeout_status, 9'h0}
                    | {31'h0, st.bus_error_status};
                default: next_st.rsp.rdata = 32'h0;
            endcase
        end

        // frame tracking
        if (bus_start_i) begin
            next_st.in_frame = 1'b1;
            next_st.sext_cnt = 32'h0;
            next_st.mext_cnt = 32'h0;
        end
        if (bus_ack_i) begin
            next_st.mext_cnt = 32'h0;
        end
        if (bus_stop_i) begin
            next_st.in_frame = 1'b0;
            next_st.bus = BUS_IDLE;
        end
        if (st.in_frame && scl_low && st.module_enabled) begin
            next_st.sext_cnt = st.sext_cnt + 32'h1;
            next_st.mext_cnt = next_st.mext_cnt + 32'h1;
        end
        if (st.ctrl_a[A_SEXT] && st.sext_cnt > 32'(SLAVE_EXT_LIMIT)) begin
            extend_hit = 1'b1;
        end
        if (st.ctrl_a[A_MEXT] && st.mext_cnt > 32'(MASTER_EXT_LIMIT)) begin
            extend_hit = 1'b1;
        end
        if (extend_hit && st.in_frame) begin
            // leaving the frame stops the counters firing again
            next_st.in_frame = 1'b0;
            next_st.op.stop = 1'b1;
            next_st.clock_hold_release = 1'b1;
            next_st.master_on_bus_flag = 1'b1;
            next_st.extend_timeout_status = 1'b1;
            next_st.bus_error_status = 1'b1;
        end else if (bus_start_i) begin
            next_st.master_on_bus_flag = 1'b0;
        end else if (bus_ack_i) begin
            // a finished byte gives the bus back to software
            next_st.master_on_bus_flag = 1'b1;
        end
        if (st.in_frame && !bus_stop_i && st.bus != BUS_OWNER) begin
            next_st.bus = BUS_OWNER;
        end

        // inactivity: scl period counted from rise to rise
        if (scl_rise) begin
            // last full period is held, the running count grows while scl is pinned
            next_st.scl_period = st.period_cnt;
            next_st.period_cnt = 16'h0;
        end else if (st.period_cnt != 16'hffff) begin
            next_st.period_cnt = st.period_cnt + 16'h1;
        end
        if (scl_fall) begin
            next_st.scl_low_cnt = 16'h0;
            next_st.low_periods = 5'h0;
        end else if (scl_low) begin
            if (st.scl_low_cnt >= st.scl_period && st.scl_period != 16'h0) begin
                next_st.scl_low_cnt = 16'h0;
                if (st.low_periods != 5'h1f) begin
                    next_st.low_periods = st.low_periods + 5'h1;
                end
            end else begin
                next_st.scl_low_cnt = st.scl_low_cnt + 16'h1;
            end
        end
        if (inact_limit(st.ctrl_a[A_INACT_LO +: 2]) != 5'h0 && scl_low
            && st.low_periods >= inact_limit(st.ctrl_a[A_INACT_LO +: 2])) begin
            next_st.bus = BUS_IDLE;
        end

        // the clock request drops one cycle after module_enabled falls
        next_st.core_clock_en = (~standby_i | st.ctrl_a[A_STANDBY]) & st.module_enabled;
        next_st.hold_cycles = hold_sel(next_st.ctrl_a[A_HOLD_LO +: 2]);

        if (sys_rst_i) begin
            next_st = '0;
            next_st.scl_sync = 2'h3;
            next_st.scl_prev = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        st <= next_st;
    end

    assign rsp_o = st.rsp;
    assign op_o = st.op;
    assign core_clock_en_o = st.core_clock_en;
    assign module_enabled_o = st.module_enabled;
    assign four_wire_o = st.ctrl_a[A_FOUR_WIRE];
    assign speed_o = st.ctrl_a[A_SPEED_LO +: 2];
    assign hold_cycles_o = st.hold_cycles;
    assign stretch_after_ack_o = st.ctrl_a[A_STRETCH];
    assign bus_state_o = st.bus;
    assign clock_hold_release_o = st.clock_hold_release;
    assign extend_timeout_status_o = st.extend_timeout_status;
    assign bus_error_status_o = st.bus_error_status;
    assign master_on_bus_flag_o = st.master_on_bus_flag;
endmodule : imc_master_control

/* File: testbench/imc_master_control_sva.sv */
// port assertions for the two-wire master control block
`timescale 1ns/10ps
module imc_master_control_sva #(
    parameter int SLAVE_EXT_LIMIT = 200,
    parameter int MASTER_EXT_LIMIT = 200
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire imc_pkg::imc_req_type req_i,
    input wire logic master_reading_i,
    input wire logic addr_write_i,
    input wire logic standby_i,
    input wire imc_pkg::imc_rsp_type rsp_o,
    input wire imc_pkg::imc_op_type op_o,
    input wire logic core_clock_en_o,
    input wire logic module_enabled_o,
    input wire logic extend_timeout_status_o,
    input wire logic bus_error_status_o,
    input wire logic master_on_bus_flag_o
);
    import imc_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic live;
    logic cmd_wr;
    logic [1:0] cmd;
    // only commands issued while software may issue them count
    assign live = module_enabled_o && master_on_bus_flag_o;
    assign cmd_wr = req_i.wr && req_i.addr == OFS_CTRL_B && live;
    assign cmd = req_i.wdata[B_CMD_LO +: 2];
    stop_cmd_a: assert property (cmd_wr && cmd == 2'h3 |=> op_o.stop || rsp_o.err)
        else $error("stop command gave no stop");
    restart_cmd_a: assert property (cmd_wr && cmd == 2'h1 |=> op_o.restart || rsp_o.err)
        else $error("restart command gave no restart");
    read_cmd_a: assert property (cmd_wr && cmd == 2'h2 && master_reading_i
        |=> op_o.read_byte || rsp_o.err) else $error("read command gave no byte read");
    write_noread_a: assert property (cmd_wr && !master_reading_i |=> !op_o.read_byte)
        else $error("byte read while writing");
    ack_value_a: assert property (cmd_wr && cmd != 2'h0 && master_reading_i
        |=> rsp_o.err || (op_o.ack_valid && op_o.send_nack == $past(req_i.wdata[B_ACK])))
        else $error("acknowledge action not the one written");
    ack_write_a: assert property (cmd_wr && !master_reading_i |=> !op_o.ack_valid)
        else $error("acknowledge action while writing");
    addr_restart_a: assert property (addr_write_i && live |=> op_o.restart)
        else $error("address write gave no restart");
    ext_error_a: assert property ($rose(extend_timeout_status_o) |-> ##[0:2] bus_error_status_o)
        else $error("extend timeout without bus error");
    clock_run_a: assert property ((module_enabled_o && !standby_i) [*3] |-> core_clock_en_o)
        else $error("core clock stopped outside standby");
endmodule : imc_master_control_sva

bind imc_master_control imc_master_control_sva #(
    .SLAVE_EXT_LIMIT(SLAVE_EXT_LIMIT),
    .MASTER_EXT_LIMIT(MASTER_EXT_LIMIT)
) u_sva (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .master_reading_i(master_reading_i), .addr_write_i(addr_write_i),
    .standby_i(standby_i), .rsp_o(rsp_o), .op_o(op_o), .core_clock_en_o(core_clock_en_o),
    .module_enabled_o(module_enabled_o), .extend_timeout_status_o(extend_timeout_status_o),
    .bus_error_status_o(bus_error_status_o), .master_on_bus_flag_o(master_on_bus_flag_o)
);

/* File: testbench/imc_slave_model.sv */
// slave side of the bus: clocks frames, may pin the clock low
`timescale 1ns/10ps
module imc_slave_model (
    input wire logic run_i,
    input wire logic stretch_i,
    output logic scl_o
);
    logic link_clk;
    initial begin
        link_clk = 1'b1;
        forever #62.5 link_clk = ~link_clk;
    end
    // pull-up keeps the line high outside frames
    assign scl_o = stretch_i ? 1'b0 : (run_i ? link_clk : 1'b1);
endmodule : imc_slave_model

/* File: testbench/tb.sv */
// self-checking bench for the master control block
`timescale 1ns/10ps
module tb;
    import imc_pkg::*;
    typedef struct packed {
        logic [31:0] d;
        logic [1:0] sp;
        logic fw;
        logic st;
        logic [7:0] hd;
    } imc_row_type;
    logic clock_i, sys_rst_i, master_reading_i, data_read_i, addr_write_i, op_done_i;
    logic bus_start_i, bus_ack_i, bus_stop_i, standby_i, scl_i, run, stretch;
    logic core_clock_en_o, module_enabled_o, four_wire_o, stretch_after_ack_o;
    logic clock_hold_release_o, extend_timeout_status_o, bus_error_status_o;
    logic master_on_bus_flag_o;
    logic [1:0] speed_o;
    logic [5:0] hold_cycles_o;
    imc_req_type req_i;
    imc_rsp_type rsp_o, rs;
    imc_op_type op_o, op;
    imc_bus_type bus_state_o;
    int failures, compares, i, r;
    logic rd;
    logic [1:0] cm;
    imc_row_type rows [4] = '{
        '{32'h0000_0014, 2'h0, 1'b0, 1'b0, 8'h00},
        '{32'h0911_0014, 2'h1, 1'b1, 1'b1, 8'(HOLD1_CYCLES)},
        '{32'h0220_0014, 2'h2, 1'b0, 1'b0, 8'(HOLD2_CYCLES)},
        '{32'h1870_0014, 2'h0, 1'b0, 1'b1, 8'(HOLD3_CYCLES)}};
    imc_slave_model slave (.run_i(run), .stretch_i(stretch), .scl_o(scl_i));
    imc_master_control #(.SLAVE_EXT_LIMIT(400), .MASTER_EXT_LIMIT(200)) dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .scl_i(scl_i),
        .master_reading_i(master_reading_i), .data_read_i(data_read_i),
        .addr_write_i(addr_write_i), .op_done_i(op_done_i), .bus_start_i(bus_start_i),
        .bus_ack_i(bus_ack_i), .bus_stop_i(bus_stop_i), .standby_i(standby_i), .rsp_o(rsp_o),
        .op_o(op_o), .core_clock_en_o(core_clock_en_o), .module_enabled_o(module_enabled_o),
        .four_wire_o(four_wire_o), .speed_o(speed_o), .hold_cycles_o(hold_cycles_o),
        .stretch_after_ack_o(stretch_after_ack_o), .bus_state_o(bus_state_o),
        .clock_hold_release_o(clock_hold_release_o),
        .extend_timeout_status_o(extend_timeout_status_o),
        .bus_error_status_o(bus_error_status_o), .master_on_bus_flag_o(master_on_bus_flag_o));
    task cyc;
        @(negedge clock_i);
    endtask : cyc
    // one access, then an idle cycle so strobes never change twice in a step
    task acc(input logic [7:0] a, input logic [31:0] d, input logic w);
        req_i = '{addr: a, wdata: d, wr: w, rd: !w};
        cyc;
        rs = rsp_o;
        op = op_o;
        req_i = '0;
        cyc;
    endtask : acc
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {master_reading_i, data_read_i, addr_write_i, op_done_i} = '0;
        {bus_start_i, bus_ack_i, bus_stop_i, standby_i, run, stretch} = '0;
        req_i = '0;
        sys_rst_i = 1'b1;
        repeat (6) cyc;
        sys_rst_i = 1'b0;
        acc(OFS_CTRL_A, 0, 0);
        chk("ctrl_a reset", CTRL_A_RESET, rs.rdata);
        acc(OFS_CTRL_B, 0, 0);
        chk("ctrl_b reset", CTRL_B_RESET, rs.rdata);
        for (r = 0; r < 4; r++) begin
            acc(OFS_CTRL_A, rows[r].d, 1);
            acc(OFS_CTRL_A, 0, 0);
            chk("ctrl_a", rows[r].d, rs.rdata);
            chk("speed", rows[r].sp, speed_o);
            chk("four_wire", rows[r].fw, four_wire_o);
            chk("stretch", rows[r].st, stretch_after_ack_o);
            chk("hold", rows[r].hd, hold_cycles_o);
        end
        acc(OFS_CTRL_A, 32'h1870_0016, 1);
        acc(OFS_SYNC, 0, 0);
        chk("enable busy", 1, rs.rdata[1]);
        acc(OFS_CTRL_A, 0, 0);
        chk("enable readback", 1, rs.rdata[A_ENABLE]);
        for (i = 0; i < 50 && module_enabled_o !== 1'b1; i++) cyc;
        acc(OFS_SYNC, 0, 0);
        chk("enable done", 0, rs.rdata[1]);
        chk("enabled", 1, module_enabled_o);
        chk("clock running", 1, core_clock_en_o);
        standby_i = 1'b1;
        repeat (3) cyc;
        chk("clock gated", 0, core_clock_en_o);
        standby_i = 1'b0;
        bus_start_i = 1'b1;
        cyc;
        bus_start_i = 1'b0;
        for (r = 0; r < 8; r++) begin
            cm = r[1:0];
            rd = !r[2];
            master_reading_i = rd;
            bus_ack_i = 1'b1;
            cyc;
            bus_ack_i = 1'b0;
            chk("bus flag", 1, master_on_bus_flag_o);
            acc(OFS_CTRL_B, (32'(cm) << B_CMD_LO) | (32'(^cm) << B_ACK), 1);
            chk("op", {cm == 2'h1, rd && cm == 2'h2, cm == 2'h3, rd && cm != 2'h0},
                {op.restart, op.read_byte, op.stop, op.ack_valid});
            if (rd && cm != 2'h0) chk("nack", ^cm, op.send_nack);
            acc(OFS_SYNC, 0, 0);
            chk("op busy", cm != 2'h0, rs.rdata[2]);
            op_done_i = 1'b1;
            cyc;
            op_done_i = 1'b0;
            acc(OFS_CTRL_B, 0, 0);
            chk("cmd field", {^cm, 2'h0}, rs.rdata[18:16]);
        end
        bus_ack_i = 1'b1;
        cyc;
        bus_ack_i = 1'b0;
        addr_write_i = 1'b1;
        cyc;
        op = op_o;
        addr_write_i = 1'b0;
        chk("address restart", 1, op.restart);
        master_reading_i = 1'b1;
        acc(OFS_CTRL_B, 32'h0004_0100, 1);
        data_read_i = 1'b1;
        cyc;
        op = op_o;
        data_read_i = 1'b0;
        chk("smart nack", 2'h3, {op.ack_valid, op.send_nack});
        bus_stop_i = 1'b1;
        cyc;
        bus_stop_i = 1'b0;
        chk("stop idle", BUS_IDLE, bus_state_o);
        bus_start_i = 1'b1;
        cyc;
        bus_start_i = 1'b0;
        run = 1'b1;
        repeat (80) cyc;
        // pin the clock low from the middle of a high phase
        for (i = 0; i < 20 && scl_i !== 1'b0; i++) cyc;
        for (i = 0; i < 20 && scl_i !== 1'b1; i++) cyc;
        if (i == 20) failures++;
        repeat (3) cyc;
        run = 1'b0;
        stretch = 1'b1;
        for (i = 0; i < 300 && bus_state_o !== BUS_IDLE; i++) cyc;
        chk("inactive window", 1, i >= 75 && i <= 100);
        chk("idle", BUS_IDLE, bus_state_o);
        for (i = 0; i < 400 && extend_timeout_status_o !== 1'b1; i++) cyc;
        chk("extend", 1, extend_timeout_status_o);
        chk("bus error", 1, bus_error_status_o);
        chk("hold release", 1, clock_hold_release_o);
        chk("auto stop", 1, op_o.stop);
        chk("extend flag", 1, master_on_bus_flag_o);
        stretch = 1'b0;
        acc(OFS_CTRL_A, 32'h0000_0017, 1);
        acc(OFS_CTRL_B, 32'h0000_0100, 1);
        chk("write in reset", 1, rs.err);
        rs.rdata = '1;
        for (i = 0; i < 50 && rs.rdata[0] !== 1'b0; i++) acc(OFS_SYNC, 0, 0);
        acc(OFS_CTRL_A, 0, 0);
        chk("ctrl_a cleared", 0, rs.rdata);
        chk("disabled", 0, module_enabled_o);
        acc(OFS_CTRL_B, 0, 0);
        chk("ctrl_b cleared", 0, rs.rdata);
        tally_and_finish();
    end
endmodule : tb
